// File: rtl/lcd_cmd_consts.vh
/*
 Command codes, geometry limits and reset values for the LCD command decoder.
 Assumes inclusion by the decoder only; definitions only.
*/
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH
// Command codes (full byte compare unless masked)
`define CMD_DISP_ONOFF    7'h57
`define CMD_START_LINE    2'h1
`define CMD_PAGE_SET      4'hb
`define CMD_COL_HIGH      4'h1
`define CMD_COL_LOW       4'h0
`define CMD_SEG_DIR       7'h50
`define CMD_INVERSE       7'h53
`define CMD_ALL_ON        7'h52
`define CMD_BIAS          7'h51
`define CMD_RMW           8'he0
`define CMD_END           8'hee
`define CMD_SOFT_RESET    8'he2
`define CMD_COM_SCAN      4'hc
`define CMD_POWER         5'h05
`define CMD_RATIO         5'h04
`define CMD_VOL_MODE      8'h81
`define CMD_NOP           8'he3
`define CMD_STATIC_OFF    8'hac
`define CMD_STATIC_ON     8'had
`define CMD_TEST          6'h3f
// Geometry
`define COL_LAST          7'h5f
`define PAGE_LAST         3'h4
// Reset values
`define RST_VOLUME        6'h20
`define RST_RATIO         3'h0
`endif

// File: rtl/lcd_command_decoder.v
/*
 LCD controller command decoder: classifies host bus accesses, executes
 commands, and keeps the display RAM with its page and column addressing.
 Assumes the host bus pins are asynchronous (synchronised here) and that a
 host strobe stays active for at least three clk_sys cycles.
*/
// Notes on behaviour
// R1 - Data write stores byte, column advances
// R2 - Data read returns byte, column advances
// R3 - Host discards one dummy read first
// R4 - Serial interface has no read path
// R5 - D0 selects segment order, increment unaffected
// R6 - D0 selects display inversion, RAM untouched
// R7 - All-points-on overrides inversion, RAM kept
// R8 - All-on while display off enters power save
// R9 - D0 selects one-sixth or one-fifth bias
// R10 - Read-modify-write saves column, reads hold
// R11 - END restores saved column, leaves mode
// R12 - Other commands work during read-modify-write
// R13 - Soft reset clears listed settings only
// R14 - Host uses hardware reset at power-up
// R15 - D3 selects common scan direction
// R16 - D2 booster, D1 regulator, D0 follower
// R17 - Low three bits load resistor ratio
// R18 - Volume mode accepts only volume byte
// R19 - Host sends volume pair back to back
// R20 - Low six bits load volume register
// R21 - Access type from select and strobes
// R22 - Serial bytes arrive MSB first
// R23 - Column stops at last, no page carry
// R24 - Undefined command codes are ignored
`include "lcd_cmd_consts.vh"
`default_nettype none

module lcd_command_decoder (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       reset_n,
    // Interface selection (strap levels)
    input  wire       serial_mode,
    input  wire       bus_6800,
    // Parallel host bus
    input  wire       chip_select_n,
    input  wire       reg_select,
    input  wire       rd_n_e,
    input  wire       wr_n_rw,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe_n,
    // Serial host bus
    input  wire       serial_clk,
    input  wire       serial_data,
    // Display settings
    output reg        display_on,
    output reg  [4:0] start_line,
    output reg  [2:0] page_addr,
    output reg  [6:0] col_addr,
    output reg        seg_reverse,
    output reg        display_inverse,
    output reg        all_points_on,
    output reg        power_save,
    output reg        bias_fifth,
    output reg        com_reverse,
    output reg        booster_on,
    output reg        regulator_on,
    output reg        follower_on,
    output reg  [2:0] regulator_resistor_ratio,
    output reg  [5:0] volume,
    output reg        static_on,
    output reg  [1:0] static_blink,
    output reg        rmw_active,
    output reg        test_active
);

    // Two-flop synchronisers for every host bus and strap pin
    reg [15:0] sync_a;
    reg [15:0] sync_b;
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync_a <= 16'hffff;
            sync_b <= 16'hffff;
        end
        else
        begin
            sync_a <= {bus_6800, serial_clk, serial_data, chip_select_n, reg_select, rd_n_e, wr_n_rw,
                       data_in, serial_mode};
            sync_b <= sync_a;
        end
    end
    wire       s_m68  = sync_b[15];   // Strap too, so a late strap change cannot glitch decode
    wire       s_sclk = sync_b[14];
    wire       s_sdat = sync_b[13];
    wire       s_cs_n = sync_b[12];
    wire       s_a0   = sync_b[11];
    wire       s_rde  = sync_b[10];
    wire       s_wrrw = sync_b[9];
    wire [7:0] s_data = sync_b[8:1];
    wire       s_ser  = sync_b[0];

    // Strobe activity per bus style
    wire rd_act = !s_cs_n && (s_m68 ? (s_rde && s_wrrw) : !s_rde);      // [R21]
    wire wr_act = !s_cs_n && (s_m68 ? (s_rde && !s_wrrw) : !s_wrrw);    // [R21]
    reg  rd_prev;
    reg  wr_prev;
    reg  sclk_prev;
    reg  [2:0] bit_cnt;
    reg  [6:0] shift;

    // Access events: parallel writes act on strobe release, serial writes on the eighth clock rise, reads on strobe start
    wire par_wr = !s_ser && wr_prev && !wr_act;
    wire par_rd = !s_ser && rd_act && !rd_prev;                         // [R4]
    wire ser_bit = s_ser && !s_cs_n && s_sclk && !sclk_prev;
    wire ser_byte = ser_bit && (bit_cnt == 3'h7);
    wire       wr_evt = par_wr || ser_byte;
    wire [7:0] wr_byte = s_ser ? {shift, s_sdat} : s_data;              // [R22]
    wire       wr_is_data = s_a0;                                       // [R21]
    wire       rd_is_data = s_a0;                                       // [R21]

    // Serial shifter, MSB first; reg_select sampled at the last bit
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_prev   <= 1'b0;
            wr_prev   <= 1'b0;
            sclk_prev <= 1'b0;
            bit_cnt   <= 3'h0;
            shift     <= 7'h00;
        end
        else
        begin
            rd_prev   <= rd_act;
            wr_prev   <= wr_act;
            sclk_prev <= s_sclk;
            if (s_cs_n)
                bit_cnt <= 3'h0;                 // Frame realigns on deselect
            else if (ser_bit)
            begin
                bit_cnt <= bit_cnt + 3'h1;
                shift   <= {shift[5:0], s_sdat}; // [R22]
            end
        end
    end

    // Display RAM: five pages of 96 columns, flops indexed by page*96+col
    reg [7:0] ram [0:479];
    function [8:0] ram_index;
        input [2:0] pg;
        input [6:0] cl;
        begin
            ram_index = {pg, 6'h00} + {1'b0, pg, 5'h00} + {2'h0, cl};
        end
    endfunction
    function [6:0] col_step;
        input [6:0] cl;
        begin
            col_step = (cl >= `COL_LAST) ? `COL_LAST : cl + 7'h01;      // [R23]
        end
    endfunction
    wire addr_ok = (page_addr <= `PAGE_LAST) && (col_addr <= `COL_LAST);

    // RAM write port
    always @(posedge clk_sys)
    begin
        if (wr_evt && wr_is_data && addr_ok)
            ram[ram_index(page_addr, col_addr)] <= wr_byte;             // [R1]
    end

    reg [6:0] saved_col;
    reg       vol_mode;
    reg       static_mode;
    reg [7:0] read_latch;

    // Command execution and address updates
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            display_on               <= 1'b0;
            start_line               <= 5'h00;
            page_addr                <= 3'h0;
            col_addr                 <= 7'h00;
            seg_reverse              <= 1'b0;
            display_inverse          <= 1'b0;
            all_points_on            <= 1'b0;
            power_save               <= 1'b0;
            bias_fifth               <= 1'b0;
            com_reverse              <= 1'b0;
            booster_on               <= 1'b0;
            regulator_on             <= 1'b0;
            follower_on              <= 1'b0;
            regulator_resistor_ratio <= `RST_RATIO;
            volume                   <= `RST_VOLUME;
            static_on                <= 1'b0;
            static_blink             <= 2'h0;
            rmw_active               <= 1'b0;
            test_active              <= 1'b0;
            saved_col                <= 7'h00;
            vol_mode                 <= 1'b0;
            static_mode              <= 1'b0;
            data_out                 <= 8'h00;
            data_oe_n                <= 1'b1;
            read_latch               <= 8'h00;
        end
        else
        begin
            // Data bus drive; status read has no data latency
            data_oe_n <= !(rd_act && !s_ser);                           // [R4]
            if (par_rd && rd_is_data)
            begin
                // Pipelined: each read shows the byte fetched by the last, hence the dummy read
                data_out   <= read_latch;                               // [R3]
                read_latch <= addr_ok ? ram[ram_index(page_addr, col_addr)] : 8'h00; // [R2]
                if (!rmw_active)
                    col_addr <= col_step(col_addr);                     // [R2] [R10]
            end
            else if (par_rd)
                data_out <= {1'b0, seg_reverse, !display_on, 1'b0, 4'h0};
            if (wr_evt && wr_is_data)
                col_addr <= col_step(col_addr);                         // [R1] [R10] [R5]
            else if (wr_evt && vol_mode)
            begin
                // Only the volume byte is accepted while the mode is open
                volume   <= wr_byte[5:0];                               // [R18] [R20]
                vol_mode <= 1'b0;                                       // [R18]
            end
            else if (wr_evt && static_mode)
            begin
                static_blink <= wr_byte[1:0];
                static_mode  <= 1'b0;
            end
            else if (wr_evt)
            begin
                // Commands run regardless of read-modify-write state  [R12]
                if (wr_byte[7:1] == `CMD_DISP_ONOFF)
                begin
                    display_on <= wr_byte[0];
                    if (wr_byte[0])
                        power_save <= 1'b0;
                    else if (all_points_on)
                        power_save <= 1'b1;
                end
                else if (wr_byte[7:6] == `CMD_START_LINE)
                    start_line <= wr_byte[4:0];
                else if (wr_byte[7:4] == `CMD_PAGE_SET)
                    page_addr <= wr_byte[2:0];
                else if (wr_byte[7:4] == `CMD_COL_HIGH)
                    col_addr <= {wr_byte[2:0], col_addr[3:0]};
                else if (wr_byte[7:4] == `CMD_COL_LOW)
                    col_addr <= {col_addr[6:4], wr_byte[3:0]};
                else if (wr_byte[7:1] == `CMD_SEG_DIR)
                    seg_reverse <= wr_byte[0];                          // [R5]
                else if (wr_byte[7:1] == `CMD_INVERSE)
                    display_inverse <= wr_byte[0];                      // [R6]
                else if (wr_byte[7:1] == `CMD_ALL_ON)
                begin
                    all_points_on <= wr_byte[0];                        // [R7]
                    power_save    <= wr_byte[0] && !display_on;         // [R8]
                end
                else if (wr_byte[7:1] == `CMD_BIAS)
                    bias_fifth <= wr_byte[0];                           // [R9]
                else if (wr_byte == `CMD_RMW)
                begin
                    rmw_active <= 1'b1;                                 // [R10]
                    saved_col  <= col_addr;                             // [R10]
                end
                else if (wr_byte == `CMD_END)
                begin
                    if (rmw_active)
                        col_addr <= saved_col;                          // [R11]
                    rmw_active <= 1'b0;                                 // [R11]
                end
                else if (wr_byte == `CMD_SOFT_RESET)
                begin
                    // Display RAM and power enables stay as they are
                    start_line               <= 5'h00;                  // [R13]
                    col_addr                 <= 7'h00;                  // [R13]
                    page_addr                <= 3'h0;                   // [R13]
                    com_reverse              <= 1'b0;                   // [R13]
                    regulator_resistor_ratio <= `RST_RATIO;             // [R13]
                    volume                   <= `RST_VOLUME;            // [R13]
                    static_on                <= 1'b0;                   // [R13]
                    static_blink             <= 2'h0;                   // [R13]
                    rmw_active               <= 1'b0;                   // [R13]
                    test_active              <= 1'b0;                   // [R13]
                end
                else if (wr_byte[7:4] == `CMD_COM_SCAN)
                    com_reverse <= wr_byte[3];                          // [R15]
                else if (wr_byte[7:3] == `CMD_POWER)
                begin
                    booster_on   <= wr_byte[2];                         // [R16]
                    regulator_on <= wr_byte[1];                         // [R16]
                    follower_on  <= wr_byte[0];                         // [R16]
                end
                else if (wr_byte[7:3] == `CMD_RATIO)
                    regulator_resistor_ratio <= wr_byte[2:0];           // [R17]
                else if (wr_byte == `CMD_VOL_MODE)
                    vol_mode <= 1'b1;                                   // [R18]
                else if (wr_byte == `CMD_STATIC_OFF)
                    static_on <= 1'b0;
                else if (wr_byte == `CMD_STATIC_ON)
                begin
                    static_on   <= 1'b1;
                    static_mode <= 1'b1;
                end
                else if (wr_byte == `CMD_NOP)
                    test_active <= 1'b0;
                else if (wr_byte[7:2] == `CMD_TEST)
                    test_active <= 1'b1;
                // Any other code falls through untouched  [R24]
            end
        end
    end

endmodule // lcd_command_decoder
`default_nettype wire

// File: verif/lcd_decoder_monitor.sv
/* Port checker for the LCD command decoder.
   Assumes binding to lcd_command_decoder, one clock domain. */
`default_nettype none
module lcd_decoder_monitor (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       reset_n,
    // Watched ports
    input wire logic       serial_mode,
    input wire logic       data_oe_n,
    input wire logic [2:0] page_addr,
    input wire logic [6:0] col_addr,
    input wire logic       rmw_active,
    input wire logic       display_on,
    input wire logic       all_points_on,
    input wire logic       power_save,
    input wire logic [5:0] volume,
    input wire logic       seg_reverse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [6:0] saved_col;
    // Saved column copy frozen once read-modify-write starts
    always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
            saved_col <= 7'h00;
        else if (!rmw_active)
            saved_col <= col_addr;
    reset_vals_a: assert property (
        $rose(reset_n) |-> volume == 6'h20 && col_addr == 7'h00 && data_oe_n) else $error("bad reset values");
    serial_no_drive_a: assert property (
        serial_mode && $past(serial_mode, 4) |-> data_oe_n) else $error("read driven in serial mode");
    page_no_carry_a: assert property (
        col_addr == $past(col_addr) + 7'h01 |-> $stable(page_addr)) else $error("page moved with column");
    rmw_read_hold_a: assert property (
        $fell(data_oe_n) && rmw_active |-> $stable(col_addr) [*3]) else $error("column moved on held read");
    rmw_restore_a: assert property (
        $fell(rmw_active) |-> ##[0:1] (col_addr == saved_col || col_addr == 7'h00)) else $error("column not restored");
    save_entry_a: assert property (
        $rose(all_points_on) && !display_on |-> ##[0:1] power_save) else $error("power save not entered");
    save_cause_a: assert property (
        $rose(power_save) |-> all_points_on && !display_on) else $error("power save without cause");
    save_exit_a: assert property (
        $rose(display_on) |-> ##[0:1] !power_save) else $error("power save kept with display on");
    read_quiet_a: assert property (
        !data_oe_n && $past(data_oe_n) == 1'b0 |-> $stable(volume) && $stable(seg_reverse))
        else $error("setting changed by a read");
endmodule // lcd_decoder_monitor
bind lcd_command_decoder lcd_decoder_monitor u_monitor (.clk_sys, .reset_n, .serial_mode, .data_oe_n, .page_addr,
    .col_addr, .rmw_active, .display_on, .all_points_on, .power_save, .volume, .seg_reverse);
`default_nettype wire

// File: verif/lcd_host_model.sv
/* Host processor model: 8080, 6800 and serial bus cycles.
   Assumes the decoder needs strobes of three or more cycles. */
`default_nettype none
module lcd_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Straps
    output var  logic       serial_mode,
    output var  logic       bus_6800,
    // Host bus
    output var  logic       chip_select_n,
    output var  logic       reg_select,
    output var  logic       rd_n_e,
    output var  logic       wr_n_rw,
    output var  logic [7:0] data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n,
    output var  logic       serial_clk,
    output var  logic       serial_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus, strobes inactive
    initial
    begin
        {serial_mode, bus_6800, chip_select_n, reg_select} = 4'b0010;
        {rd_n_e, wr_n_rw, serial_clk, serial_data, data_in} = {4'b1100, 8'h00};
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic set_mode(input logic ser, input logic m6800);
        serial_mode = ser;
        bus_6800 = m6800;
        rd_n_e = !m6800;
        tick(4);
    endtask
    // Data held past release, since pins pass two sync stages
    task automatic access(input logic rs, input logic rd, input logic [7:0] b, output logic [8:0] got);
        tick(1);
        chip_select_n = 1'b0;
        reg_select = rs;
        data_in = b;
        got = 9'h000;
        if (serial_mode && !rd)
            for (int i = 7; i >= 0; i--)
            begin
                serial_data = b[i];
                tick(3);
                serial_clk = 1'b1;
                tick(3);
                serial_clk = 1'b0;
            end
        else
        begin
            rd_n_e = bus_6800 | !rd;
            wr_n_rw = rd;
            tick(4);
            got = {data_oe_n, data_out};
            rd_n_e = !bus_6800;
            wr_n_rw = 1'b1;
        end
        tick(4);
        chip_select_n = 1'b1;
        data_in = ~b; // Released lines no longer show the byte
        serial_data = ~b[0];
        tick(3);
    endtask
endmodule // lcd_host_model
`default_nettype wire

// File: verif/lcd_command_decoder_test.sv
/* Self-checking bench for the LCD command decoder.
   Assumes the host model and the bound port checker. */
`default_nettype none
module lcd_command_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    wire logic  serial_mode, bus_6800, chip_select_n, reg_select, rd_n_e, wr_n_rw, serial_clk, serial_data;
    wire logic  data_oe_n, display_on, seg_reverse, display_inverse, all_points_on, power_save, bias_fifth;
    wire logic  com_reverse, booster_on, regulator_on, follower_on, rmw_active, static_on, test_active;
    wire logic [4:0] start_line;
    wire logic [1:0] static_blink;
    wire logic [7:0] data_in, data_out;
    wire logic [6:0] col_addr;
    wire logic [5:0] volume;
    wire logic [2:0] page_addr, regulator_resistor_ratio;
    logic [7:0] ram_exp [0:4][0:95];
    logic [8:0] got;
    logic [7:0] r;
    logic [6:0] col, base;
    logic [2:0] pg;
    int         err_total = 0;
    int         total_checks = 0;
    always #5 clk_sys = ~clk_sys;
    lcd_host_model u_host (.clk_sys, .serial_mode, .bus_6800, .chip_select_n, .reg_select, .rd_n_e, .wr_n_rw,
        .data_in, .data_out, .data_oe_n, .serial_clk, .serial_data);
    lcd_command_decoder u_dut (.clk_sys, .reset_n, .serial_mode, .bus_6800, .chip_select_n, .reg_select, .rd_n_e,
        .wr_n_rw, .data_in, .data_out, .data_oe_n, .serial_clk, .serial_data, .display_on, .start_line,
        .page_addr, .col_addr, .seg_reverse, .display_inverse, .all_points_on, .power_save, .bias_fifth,
        .com_reverse, .booster_on, .regulator_on, .follower_on, .regulator_resistor_ratio, .volume,
        .static_on, .static_blink, .rmw_active, .test_active);
    function automatic logic [6:0] next_col(input logic [6:0] c);
        return (c == 7'h5f) ? c : c + 7'h01; // Saturates, no page carry
    endfunction
    task automatic check_val(input logic [15:0] got_v, input logic [15:0] exp_v);
        total_checks++;
        if (got_v !== exp_v)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] b);
        u_host.access(1'b0, 1'b0, b, got);
    endtask
    task automatic goto(input logic [2:0] p, input logic [6:0] c);
        cmd({5'h16, p});
        cmd({5'h02, c[6:4]});
        cmd({4'h0, c[3:0]});
        pg = p;
        col = c;
    endtask
    task automatic wr(input logic [7:0] b);
        u_host.access(1'b1, 1'b0, b, got);
        if (col <= 7'h5f)
            ram_exp[pg][col] = b;
        col = next_col(col);
    endtask
    task automatic rd();
        u_host.access(1'b1, 1'b1, 8'h00, got);
    endtask
    // Hang guard
    initial
    begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
    initial
    begin
        void'($urandom(70909));
        repeat (12) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        u_host.tick(2);
        check_val({volume, col_addr, data_oe_n, rmw_active}, {6'h20, 7'h00, 2'b10});
        // Segment, inversion, bias and common scan modes both ways
        for (int v = 0; v < 2; v++)
        begin
            r = 8'($urandom);
            cmd({7'h50, 1'(v)});
            cmd({7'h53, 1'(v)});
            cmd({7'h51, 1'(v)});
            cmd({4'hc, 1'(v), r[2:0]});
            check_val({seg_reverse, display_inverse, bias_fifth, com_reverse}, {4{1'(v)}});
        end
        for (int k = 0; k < 5; k++)
        begin
            r = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            cmd({5'h05, r[2:0]});
            cmd({5'h04, r[5:3]});
            check_val({booster_on, regulator_on, follower_on, regulator_resistor_ratio}, {r[2:0], r[5:3]});
        end
        goto(3'($urandom_range(4)), 7'($urandom_range(90)));
        base = col;
        repeat (5) wr(8'($urandom));
        check_val({page_addr, col_addr}, {pg, col});
        goto(pg, base);
        rd(); // Dummy read after column set
        for (int k = 0; k < 5; k++)
        begin
            rd();
            check_val(got, {1'b0, ram_exp[pg][base + 7'(k)]});
        end
        check_val(col_addr, (base > 7'h59) ? 7'h5f : base + 7'h06);
        goto(3'h4, 7'h5e);
        repeat (3) wr(8'($urandom));
        check_val({page_addr, col_addr}, {3'h4, 7'h5f});
        // Read-modify-write on the 6800 style bus
        u_host.set_mode(1'b0, 1'b1);
        goto(3'h1, 7'h30);
        wr(8'($urandom));
        goto(3'h1, 7'h30);
        cmd(8'he0);
        rd();
        rd();
        check_val({got, col_addr}, {1'b0, ram_exp[1][7'h30], 7'h30});
        wr(~got[7:0]);
        cmd({7'h51, 1'b0});
        check_val({col_addr, bias_fifth, rmw_active}, {7'h31, 2'b01});
        cmd(8'hee);
        check_val({col_addr, rmw_active}, {7'h30, 1'b0});
        col = 7'h30;
        rd();
        rd();
        check_val(got, {1'b0, ram_exp[1][7'h30]});
        u_host.set_mode(1'b0, 1'b0);
        r = 8'($urandom);
        cmd({5'h04, r[5:3]});
        cmd(8'h81);
        cmd({2'h3, r[5:0]});
        check_val(volume, r[5:0]);
        cmd({7'h50, 1'b0});
        cmd(8'h81);
        cmd(8'ha1);
        check_val({volume, seg_reverse}, {6'h21, 1'b0});
        cmd(8'hf0);
        check_val({volume, regulator_resistor_ratio, col_addr}, {6'h21, r[5:3], 7'h32});
        cmd(8'hae);
        cmd(8'ha5);
        check_val({display_on, all_points_on, power_save}, 3'b011);
        u_host.access(1'b0, 1'b1, 8'h00, got);
        check_val(got, 9'h020);
        cmd(8'haf);
        cmd(8'ha4);
        check_val({display_on, all_points_on, power_save}, 3'b100);
        cmd(8'he0);
        cmd(8'hc8);
        cmd(8'h25);
        cmd({3'h2, r[4:0]});
        cmd(8'had);
        cmd({6'h00, r[1:0]});
        cmd(8'hfc);
        check_val({start_line, static_on, static_blink, test_active}, {r[4:0], 1'b1, r[1:0], 1'b1});
        goto(3'h2, 7'h40);
        cmd(8'he2);
        check_val({col_addr, page_addr, com_reverse, regulator_resistor_ratio, rmw_active}, 15'h0000);
        check_val({start_line, static_on, static_blink, test_active}, 9'h000);
        check_val({volume, seg_reverse}, {6'h20, 1'b0});
        // Serial writes, then a refused serial read
        u_host.set_mode(1'b1, 1'b0);
        goto(3'h3, 7'h10);
        r = 8'($urandom);
        wr(r);
        rd();
        check_val({got[8], page_addr, col_addr}, {4'hb, 7'h11});
        u_host.set_mode(1'b0, 1'b0);
        goto(3'h3, 7'h10);
        rd();
        rd();
        check_val(got, {1'b0, r});
        complete_run();
    end
endmodule // lcd_command_decoder_test
`default_nettype wire
